// File: insn_decode_consts.vh
// constants for the instruction format field decoder
// assumes nothing; definitions only
`ifndef INSN_DECODE_CONSTS_VH
`define INSN_DECODE_CONSTS_VH

// ----------------------------------------
// format classes
// ----------------------------------------
`define FMT_ZERO 4'h0
`define FMT_N 4'h1
`define FMT_M 4'h2
`define FMT_NM 4'h3
`define FMT_MD 4'h4
`define FMT_ND4 4'h5
`define FMT_NMD 4'h6
`define FMT_D 4'h7
`define FMT_D12 4'h8
`define FMT_ND8 4'h9
`define FMT_I 4'ha
`define FMT_NI 4'hb

// ----------------------------------------
// operand addressing modes
// ----------------------------------------
`define AM_NONE 4'h0
`define AM_REG 4'h1
`define AM_IND 4'h2
`define AM_PREDEC 4'h3
`define AM_POSTINC 4'h4
`define AM_IDX_FIRST 4'h5
`define AM_DISP_REG 4'h6
`define AM_DISP_GBASE 4'h7
`define AM_IDX_GBASE 4'h8
`define AM_PC_DISP 4'h9
`define AM_PC_REL 4'ha
`define AM_CTRL 4'hb
`define AM_ACCUM 4'hc
`define AM_IMM 4'hd
`define AM_FIRST_GPR 4'he
`define AM_TRAP 4'hf

// ----------------------------------------
// extension kinds for the extend unit
// ----------------------------------------
`define EXT_NONE 3'h0
`define EXT_ZERO4 3'h1
`define EXT_ZERO8 3'h2
`define EXT_SIGN8 3'h3
`define EXT_SIGN12 3'h4

// ----------------------------------------
// operand size scale shifts
// ----------------------------------------
`define SCALE_BYTE 2'h0
`define SCALE_WORD 2'h1
`define SCALE_LONG 2'h2

// ----------------------------------------
// field positions
// ----------------------------------------
`define OPC_HI 15
`define OPC_LO 12
`define DST_HI 11
`define DST_LO 8
`define SRC_HI 7
`define SRC_LO 4
`define LOW_HI 3
`define LOW_LO 0

`endif

// File: operand_extend.v
// operand extend unit: widens and scales a displacement or immediate
// assumes kind and scale come from the format decoder on the same clock
`timescale 1ns/10ps
module operand_extend (
    // raw field
    input wire [11:0] raw_field,
    // control
    input wire [2:0] ext_kind,
    input wire [1:0] scale_shift,
    // result
    output reg [31:0] ext_value
);
`include "insn_decode_consts.vh"

    reg [31:0] base;

    // ----------------------------------------
    // widen then scale
    // ----------------------------------------
    // combinational; the decoder registers the result
    always @* begin
        case (ext_kind)
            `EXT_ZERO4: base = {28'h0000000, raw_field[3:0]};
            `EXT_ZERO8: base = {24'h000000, raw_field[7:0]};
            `EXT_SIGN8: base = {{24{raw_field[7]}}, raw_field[7:0]};
            `EXT_SIGN12: base = {{20{raw_field[11]}}, raw_field[11:0]};
            default: base = 32'h00000000;
        endcase
        ext_value = base << scale_shift;
    end
endmodule // operand_extend

// File: insn_format_field_decoder.v
// instruction format field decoder for a 16-bit instruction word
// assumes insn_word comes from the fetch unit on clk_sys, no crossing
//
// Overview of operation
// - format and operation are chosen from the opcode bits, plus bits 7:4 when opcode 0 has low nibble 9
// - field meaning depends on opcode, not on bit position alone
// - single-destination: bits 11:8 register direct or pre-decrement store
// - single-source: bits 11:8 direct, post-increment, jump target or pc-relative
// - two-register: dest 11:8, source 7:4, with their addressing modes
// - multiply-accumulate: source field 7:4 post-increment, dest field 11:8 in accumulator mode
// - 4-bit displacement forms: base 7:4, disp 3:0, first register implicit
// - two-register displacement: dest, source and 4-bit displacement
// - 8-bit displacement: global-base access, address load or conditional branch
// - register with 8-bit displacement: pc-relative load into dest register
// - immediate forms: 8-bit immediate to global-base memory, first register, trap
// - 12-bit branch displacement sign-extended and scaled by two
// - 4-bit displacement zero-extended and scaled by operand size
// - immediate sign-extended for move, add, compare; zero for logic ops
// - trap immediate zero-extended and scaled by four
`timescale 1ns/10ps
module insn_format_field_decoder (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // instruction from fetch
    input wire insn_valid,
    input wire [15:0] insn_word,
    // decoded fields
    output reg dec_valid_r,
    output reg [3:0] fmt_class_r,
    output reg [3:0] opcode_r,
    output reg [3:0] dest_gpr_r,
    output reg [3:0] src_gpr_r,
    output reg [3:0] dst_mode_r,
    output reg [3:0] src_mode_r,
    output reg [31:0] ext_value_r,
    output reg [1:0] scale_r
);
`include "insn_decode_consts.vh"

    // ----------------------------------------
    // field slices
    // ----------------------------------------
    wire [3:0] opc = insn_word[`OPC_HI:`OPC_LO];
    wire [3:0] fld_n = insn_word[`DST_HI:`DST_LO];
    wire [3:0] fld_m = insn_word[`SRC_HI:`SRC_LO];
    wire [3:0] fld_lo = insn_word[`LOW_HI:`LOW_LO];

    // operand size from the two low bits of a sub-opcode nibble
    function [1:0] size_scale;
        input [1:0] sz;
        begin
            case (sz)
                2'h0: size_scale = `SCALE_BYTE;
                2'h1: size_scale = `SCALE_WORD;
                default: size_scale = `SCALE_LONG;
            endcase
        end
    endfunction

    reg [3:0] fmt_nxt;
    reg [3:0] dest_nxt;
    reg [3:0] src_nxt;
    reg [3:0] dmode_nxt;
    reg [3:0] smode_nxt;
    reg [2:0] ext_kind;
    reg [1:0] scale_nxt;
    wire [31:0] ext_value_nxt;

    // ----------------------------------------
    // format and operand classification
    // ----------------------------------------
    // one flat case on the opcode nibble keeps the path shallow;
    // sub-decode looks at opcode bits, and at operand bits 7:4 only for low nibble 9 under opcode 0
    always @* begin
        fmt_nxt = `FMT_ZERO;
        dest_nxt = 4'h0;
        src_nxt = 4'h0;
        dmode_nxt = `AM_NONE;
        smode_nxt = `AM_NONE;
        ext_kind = `EXT_NONE;
        scale_nxt = `SCALE_BYTE;
        case (opc)
            4'h0: begin
                case (fld_lo)
                    4'h2, 4'h9, 4'ha: begin
                        // low nibble 9 is only a register form with 2 in bits 7:4
                        if (fld_lo != 4'h9 || fld_m == 4'h2) begin
                            fmt_nxt = `FMT_N;
                            dest_nxt = fld_n;
                            dmode_nxt = `AM_REG;
                            smode_nxt = (fld_lo == 4'h9) ? `AM_NONE : `AM_CTRL;
                        end
                    end
                    4'h3: begin
                        fmt_nxt = `FMT_M;
                        src_nxt = fld_n;
                        smode_nxt = `AM_PC_REL;
                    end
                    4'h4, 4'h5, 4'h6, 4'h7: begin
                        fmt_nxt = `FMT_NM;
                        dest_nxt = fld_n;
                        src_nxt = fld_m;
                        smode_nxt = `AM_REG;
                        dmode_nxt = (fld_lo == 4'h7) ? `AM_REG : `AM_IDX_FIRST;
                        scale_nxt = size_scale(fld_lo[1:0]);
                    end
                    4'hc, 4'hd, 4'he: begin
                        fmt_nxt = `FMT_NM;
                        dest_nxt = fld_n;
                        src_nxt = fld_m;
                        smode_nxt = `AM_IDX_FIRST;
                        dmode_nxt = `AM_REG;
                        scale_nxt = size_scale(fld_lo[1:0]);
                    end
                    4'hf: begin
                        fmt_nxt = `FMT_NM;
                        dest_nxt = fld_n;
                        src_nxt = fld_m;
                        smode_nxt = `AM_POSTINC;
                        dmode_nxt = `AM_ACCUM;
                        scale_nxt = `SCALE_LONG;
                    end
                    default: fmt_nxt = `FMT_ZERO;
                endcase
            end
            4'h1, 4'h5: begin
                fmt_nxt = `FMT_NMD;
                dest_nxt = fld_n;
                src_nxt = fld_m;
                dmode_nxt = (opc == 4'h1) ? `AM_DISP_REG : `AM_REG;
                smode_nxt = (opc == 4'h1) ? `AM_REG : `AM_DISP_REG;
                ext_kind = `EXT_ZERO4;
                scale_nxt = `SCALE_LONG;
            end
            4'h2, 4'h3, 4'h6: begin
                fmt_nxt = `FMT_NM;
                dest_nxt = fld_n;
                src_nxt = fld_m;
                dmode_nxt = `AM_REG;
                smode_nxt = `AM_REG;
                if (fld_lo[3:2] == 2'h0 && fld_lo[1:0] != 2'h3) begin
                    scale_nxt = size_scale(fld_lo[1:0]);
                    if (opc == 4'h2)
                        dmode_nxt = `AM_IND;
                    else if (opc == 4'h6)
                        smode_nxt = `AM_IND;
                end else if (fld_lo[3:2] == 2'h1 && fld_lo[1:0] != 2'h3) begin
                    scale_nxt = size_scale(fld_lo[1:0]);
                    if (opc == 4'h2)
                        dmode_nxt = `AM_PREDEC;
                    else if (opc == 4'h6)
                        smode_nxt = `AM_POSTINC;
                end
            end
            4'h4: begin
                case (fld_lo)
                    4'h2, 4'h3: begin
                        fmt_nxt = `FMT_N;
                        dest_nxt = fld_n;
                        dmode_nxt = `AM_PREDEC;
                        smode_nxt = `AM_CTRL;
                        scale_nxt = `SCALE_LONG;
                    end
                    4'h6, 4'h7: begin
                        fmt_nxt = `FMT_M;
                        src_nxt = fld_n;
                        smode_nxt = `AM_POSTINC;
                        dmode_nxt = `AM_CTRL;
                        scale_nxt = `SCALE_LONG;
                    end
                    4'ha, 4'he: begin
                        fmt_nxt = `FMT_M;
                        src_nxt = fld_n;
                        smode_nxt = `AM_REG;
                        dmode_nxt = `AM_CTRL;
                    end
                    4'hb: begin
                        fmt_nxt = `FMT_M;
                        src_nxt = fld_n;
                        smode_nxt = `AM_IND;
                    end
                    4'hf: begin
                        fmt_nxt = `FMT_NM;
                        dest_nxt = fld_n;
                        src_nxt = fld_m;
                        smode_nxt = `AM_POSTINC;
                        dmode_nxt = `AM_ACCUM;
                        scale_nxt = `SCALE_WORD;
                    end
                    default: begin
                        fmt_nxt = `FMT_N;
                        dest_nxt = fld_n;
                        dmode_nxt = `AM_REG;
                    end
                endcase
            end
            4'h7, 4'he: begin
                fmt_nxt = `FMT_NI;
                dest_nxt = fld_n;
                dmode_nxt = `AM_REG;
                smode_nxt = `AM_IMM;
                ext_kind = `EXT_SIGN8;
            end
            4'h8: begin
                case (fld_n)
                    4'h0, 4'h1: begin
                        fmt_nxt = `FMT_ND4;
                        dest_nxt = fld_m;
                        smode_nxt = `AM_FIRST_GPR;
                        dmode_nxt = `AM_DISP_REG;
                        ext_kind = `EXT_ZERO4;
                        scale_nxt = size_scale(fld_n[1:0]);
                    end
                    4'h4, 4'h5: begin
                        fmt_nxt = `FMT_MD;
                        src_nxt = fld_m;
                        smode_nxt = `AM_DISP_REG;
                        dmode_nxt = `AM_FIRST_GPR;
                        ext_kind = `EXT_ZERO4;
                        scale_nxt = size_scale(fld_n[1:0]);
                    end
                    4'h8: begin
                        fmt_nxt = `FMT_I;
                        smode_nxt = `AM_IMM;
                        dmode_nxt = `AM_FIRST_GPR;
                        ext_kind = `EXT_SIGN8;
                    end
                    default: begin
                        fmt_nxt = `FMT_D;
                        dmode_nxt = `AM_PC_REL;
                        ext_kind = `EXT_SIGN8;
                        scale_nxt = `SCALE_WORD;
                    end
                endcase
            end
            4'h9, 4'hd: begin
                fmt_nxt = `FMT_ND8;
                dest_nxt = fld_n;
                dmode_nxt = `AM_REG;
                smode_nxt = `AM_PC_DISP;
                ext_kind = `EXT_ZERO8;
                scale_nxt = (opc == 4'h9) ? `SCALE_WORD : `SCALE_LONG;
            end
            4'ha, 4'hb: begin
                fmt_nxt = `FMT_D12;
                dmode_nxt = `AM_PC_REL;
                ext_kind = `EXT_SIGN12;
                scale_nxt = `SCALE_WORD;
            end
            4'hc: begin
                case (fld_n)
                    4'h0, 4'h1, 4'h2: begin
                        fmt_nxt = `FMT_D;
                        smode_nxt = `AM_FIRST_GPR;
                        dmode_nxt = `AM_DISP_GBASE;
                        ext_kind = `EXT_ZERO8;
                        scale_nxt = size_scale(fld_n[1:0]);
                    end
                    4'h4, 4'h5, 4'h6: begin
                        fmt_nxt = `FMT_D;
                        smode_nxt = `AM_DISP_GBASE;
                        dmode_nxt = `AM_FIRST_GPR;
                        ext_kind = `EXT_ZERO8;
                        scale_nxt = size_scale(fld_n[1:0]);
                    end
                    4'h3: begin
                        fmt_nxt = `FMT_I;
                        smode_nxt = `AM_IMM;
                        dmode_nxt = `AM_TRAP;
                        ext_kind = `EXT_ZERO8;
                        scale_nxt = `SCALE_LONG;
                    end
                    4'h7: begin
                        fmt_nxt = `FMT_D;
                        smode_nxt = `AM_PC_DISP;
                        dmode_nxt = `AM_FIRST_GPR;
                        ext_kind = `EXT_ZERO8;
                        scale_nxt = `SCALE_LONG;
                    end
                    4'h8, 4'h9, 4'ha, 4'hb: begin
                        fmt_nxt = `FMT_I;
                        smode_nxt = `AM_IMM;
                        dmode_nxt = `AM_FIRST_GPR;
                        ext_kind = `EXT_ZERO8;
                    end
                    default: begin
                        fmt_nxt = `FMT_I;
                        smode_nxt = `AM_IMM;
                        dmode_nxt = `AM_IDX_GBASE;
                        ext_kind = `EXT_ZERO8;
                    end
                endcase
            end
            default: begin
                fmt_nxt = `FMT_N;
                dest_nxt = fld_n;
                dmode_nxt = `AM_REG;
            end
        endcase
    end

    // ----------------------------------------
    // extension and scaling
    // ----------------------------------------
    operand_extend u_extend (
        .raw_field(insn_word[11:0]),
        .ext_kind(ext_kind),
        .scale_shift(scale_nxt),
        .ext_value(ext_value_nxt)
    );

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    // fields hold their last value when no word arrives
    always @(posedge clk_sys) begin
        if (rst) begin
            dec_valid_r <= 1'b0;
            fmt_class_r <= `FMT_ZERO;
            opcode_r <= 4'h0;
            dest_gpr_r <= 4'h0;
            src_gpr_r <= 4'h0;
            dst_mode_r <= `AM_NONE;
            src_mode_r <= `AM_NONE;
            ext_value_r <= 32'h00000000;
            scale_r <= `SCALE_BYTE;
        end else begin
            dec_valid_r <= insn_valid;
            if (insn_valid) begin
                fmt_class_r <= fmt_nxt;
                opcode_r <= opc;
                dest_gpr_r <= dest_nxt;
                src_gpr_r <= src_nxt;
                dst_mode_r <= dmode_nxt;
                src_mode_r <= smode_nxt;
                ext_value_r <= ext_value_nxt;
                scale_r <= scale_nxt;
            end
        end
    end
endmodule // insn_format_field_decoder

// File: fetch_model.sv
// fetch-side model: offers instruction words to the decoder
// assumes the bench calls offer/idle; inputs change on the falling edge
`timescale 1ns/10ps
module fetch_model (
    // clock
    input wire clk_sys,
    // instruction toward the decoder
    output logic insn_valid,
    output logic [15:0] insn_word
);
    // ----------------------------------------
    // drive tasks
    // ----------------------------------------
    initial begin
        insn_valid = 1'b0;
        insn_word = 16'h0000;
    end

    // one word per call; valid stays up so calls run back to back
    task automatic offer(input logic [15:0] w);
        @(negedge clk_sys);
        insn_valid <= 1'b1;
        insn_word <= w;
    endtask

    // idle bus shows the inverse word so a stale value cannot pass
    task automatic idle();
        @(negedge clk_sys);
        insn_valid <= 1'b0;
        insn_word <= ~insn_word;
    endtask
endmodule // fetch_model

// File: insn_format_field_decoder_checker.sv
// checker for the format field decoder, watching its ports only
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
`include "insn_decode_consts.vh"
module insn_format_field_decoder_checker (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // instruction in
    input wire insn_valid,
    input wire [15:0] insn_word,
    // decoded fields
    input wire dec_valid_r,
    input wire [3:0] fmt_class_r,
    input wire [3:0] opcode_r,
    input wire [3:0] dest_gpr_r,
    input wire [3:0] src_gpr_r,
    input wire [3:0] dst_mode_r,
    input wire [3:0] src_mode_r,
    input wire [31:0] ext_value_r,
    input wire [1:0] scale_r
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    valid_pulse_a: assert property (insn_valid |=> dec_valid_r)
        else $error("decode valid missing");
    idle_hold_a: assert property (!insn_valid |=> !dec_valid_r && $stable(ext_value_r))
        else $error("fields moved while idle");
    opcode_field_a: assert property (insn_valid |=> opcode_r == $past(insn_word[15:12]))
        else $error("opcode field wrong");
    far_branch_a: assert property (insn_valid && insn_word[15:13] == 3'h5 |=>
        fmt_class_r == `FMT_D12 && ext_value_r == {{19{$past(insn_word[11])}}, $past(insn_word[11:0]), 1'b0})
        else $error("12-bit branch displacement wrong");
    reg_imm_a: assert property (insn_valid && insn_word[15:12] == 4'h7 |=>
        fmt_class_r == `FMT_NI && dest_gpr_r == $past(insn_word[11:8]) &&
        ext_value_r == {{24{$past(insn_word[7])}}, $past(insn_word[7:0])})
        else $error("register immediate wrong");
    trap_vec_a: assert property (insn_valid && insn_word[15:8] == 8'hc3 |=>
        dst_mode_r == `AM_TRAP && ext_value_r == {22'h0, $past(insn_word[7:0]), 2'b00})
        else $error("trap vector offset wrong");
    long_disp_a: assert property (insn_valid && !insn_word[15] && insn_word[13:12] == 2'h1 |=>
        fmt_class_r == `FMT_NMD && src_gpr_r == $past(insn_word[7:4]) &&
        ext_value_r == {26'h0, $past(insn_word[3:0]), 2'b00})
        else $error("two-register displacement wrong");
    pc_load_a: assert property (insn_valid && insn_word[15:12] == 4'h9 |=>
        fmt_class_r == `FMT_ND8 && dest_gpr_r == $past(insn_word[11:8]) &&
        src_mode_r == `AM_PC_DISP && ext_value_r == {23'h0, $past(insn_word[7:0]), 1'b0})
        else $error("pc relative load wrong");
    mac_src_a: assert property (insn_valid && insn_word[3:0] == 4'hf &&
        (insn_word[15:12] == 4'h0 || insn_word[15:12] == 4'h4) |=>
        dst_mode_r == `AM_ACCUM && src_mode_r == `AM_POSTINC)
        else $error("multiply-accumulate operands wrong");
    cond_branch_a: assert property (insn_valid && insn_word[15:8] == 8'h8b |=>
        fmt_class_r == `FMT_D && ext_value_r == {{23{$past(insn_word[7])}}, $past(insn_word[7:0]), 1'b0})
        else $error("conditional branch displacement wrong");
    word_disp_a: assert property (insn_valid && insn_word[15:8] == 8'h85 |=>
        fmt_class_r == `FMT_MD && dst_mode_r == `AM_FIRST_GPR &&
        ext_value_r == {27'h0, $past(insn_word[3:0]), 1'b0})
        else $error("word displacement load wrong");
endmodule // insn_format_field_decoder_checker

bind insn_format_field_decoder insn_format_field_decoder_checker insn_format_field_decoder_checker_i (
    .clk_sys(clk_sys), .rst(rst), .insn_valid(insn_valid), .insn_word(insn_word),
    .dec_valid_r(dec_valid_r), .fmt_class_r(fmt_class_r), .opcode_r(opcode_r),
    .dest_gpr_r(dest_gpr_r), .src_gpr_r(src_gpr_r), .dst_mode_r(dst_mode_r),
    .src_mode_r(src_mode_r), .ext_value_r(ext_value_r), .scale_r(scale_r)
);

// File: tb_insn_format_field_decoder.sv
// self-checking bench for the format field decoder
// assumes the fetch model drives on falling edges; results one cycle later
`timescale 1ns/10ps
`include "insn_decode_consts.vh"
`define chk(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end
module tb_insn_format_field_decoder;
    // ----------------------------------------
    // clock, reset, wiring
    // ----------------------------------------
    logic clk_sys, rst, insn_valid, dec_valid_r;
    logic [15:0] insn_word;
    logic [3:0] fmt_class_r, opcode_r, dest_gpr_r, src_gpr_r, dst_mode_r, src_mode_r;
    logic [31:0] ext_value_r;
    logic [1:0] scale_r;
    int bad_count = 0;
    int n_checks = 0;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    fetch_model fetch_model_i (.clk_sys(clk_sys), .insn_valid(insn_valid), .insn_word(insn_word));
    insn_format_field_decoder insn_format_field_decoder_i (
        .clk_sys(clk_sys), .rst(rst), .insn_valid(insn_valid), .insn_word(insn_word),
        .dec_valid_r(dec_valid_r), .fmt_class_r(fmt_class_r), .opcode_r(opcode_r),
        .dest_gpr_r(dest_gpr_r), .src_gpr_r(src_gpr_r), .dst_mode_r(dst_mode_r),
        .src_mode_r(src_mode_r), .ext_value_r(ext_value_r), .scale_r(scale_r)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    // one word in, result judged after the taking edge has landed
    task automatic dec(input logic [15:0] w, input logic [3:0] cls, input logic [3:0] dm,
                       input logic [3:0] sm, input logic [31:0] ext);
        fetch_model_i.offer(w);
        @(posedge clk_sys);
        #1;
        `chk(dec_valid_r, 1'b1)
        `chk(opcode_r, w[15:12])
        `chk(fmt_class_r, cls)
        `chk(dst_mode_r, dm)
        `chk(src_mode_r, sm)
        `chk(ext_value_r, ext)
    endtask

    task automatic stop_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // both displacement signs, back to back, then idle hold
    task automatic test_far_branch();
        dec(16'ha801, `FMT_D12, `AM_PC_REL, `AM_NONE, 32'hfffff002);
        `chk(scale_r, 2'h1)
        dec(16'ha7ff, `FMT_D12, `AM_PC_REL, `AM_NONE, 32'h00000ffe);
        fetch_model_i.idle();
        @(posedge clk_sys);
        #1;
        `chk(dec_valid_r, 1'b0)
        `chk(ext_value_r, 32'h00000ffe)
        dec(16'h0009, `FMT_ZERO, `AM_NONE, `AM_NONE, 32'h0);
    endtask

    // sign versus zero extension by operation, trap scaling
    task automatic test_immediates();
        dec(16'h7380, `FMT_NI, `AM_REG, `AM_IMM, 32'hffffff80);
        `chk(dest_gpr_r, 4'h3)
        dec(16'hc980, `FMT_I, `AM_FIRST_GPR, `AM_IMM, 32'h00000080);
        dec(16'hc3ff, `FMT_I, `AM_TRAP, `AM_IMM, 32'h000003fc);
        dec(16'hcd80, `FMT_I, `AM_IDX_GBASE, `AM_IMM, 32'h00000080);
    endtask

    // short displacements scaled by size, first register implicit
    task automatic test_disp4();
        dec(16'h8523, `FMT_MD, `AM_FIRST_GPR, `AM_DISP_REG, 32'h6);
        `chk(src_gpr_r, 4'h2)
        dec(16'h8134, `FMT_ND4, `AM_DISP_REG, `AM_FIRST_GPR, 32'h8);
        `chk(dest_gpr_r, 4'h3)
        dec(16'h1234, `FMT_NMD, `AM_DISP_REG, `AM_REG, 32'h10);
        dec(16'h523f, `FMT_NMD, `AM_REG, `AM_DISP_REG, 32'h3c);
        `chk(dest_gpr_r, 4'h2)
    endtask

    // same field positions, different addressing per opcode
    task automatic test_two_reg();
        dec(16'h6236, `FMT_NM, `AM_REG, `AM_POSTINC, 32'h0);
        `chk(src_gpr_r, 4'h3)
        dec(16'h2136, `FMT_NM, `AM_PREDEC, `AM_REG, 32'h0);
        dec(16'h0136, `FMT_NM, `AM_IDX_FIRST, `AM_REG, 32'h0);
        dec(16'h4a5f, `FMT_NM, `AM_ACCUM, `AM_POSTINC, 32'h0);
    endtask

    // single-register forms
    task automatic test_single();
        dec(16'h0529, `FMT_N, `AM_REG, `AM_NONE, 32'h0);
        `chk(dest_gpr_r, 4'h5)
        dec(16'h4303, `FMT_N, `AM_PREDEC, `AM_CTRL, 32'h0);
        dec(16'h4707, `FMT_M, `AM_CTRL, `AM_POSTINC, 32'h0);
        `chk(src_gpr_r, 4'h7)
        dec(16'h472b, `FMT_M, `AM_NONE, `AM_IND, 32'h0);
        dec(16'h0723, `FMT_M, `AM_NONE, `AM_PC_REL, 32'h0);
    endtask

    // 8-bit displacements: global base, address load, branch, pc load
    task automatic test_disp8();
        dec(16'hc603, `FMT_D, `AM_FIRST_GPR, `AM_DISP_GBASE, 32'hc);
        dec(16'hc702, `FMT_D, `AM_FIRST_GPR, `AM_PC_DISP, 32'h8);
        dec(16'h8bfe, `FMT_D, `AM_PC_REL, `AM_NONE, 32'hfffffffc);
        dec(16'h9205, `FMT_ND8, `AM_REG, `AM_PC_DISP, 32'ha);
        `chk(dest_gpr_r, 4'h2)
        fetch_model_i.idle();
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        test_far_branch();
        test_immediates();
        test_disp4();
        test_two_reg();
        test_single();
        test_disp8();
        repeat (2) @(posedge clk_sys);
        stop_test();
    end

    // whole run is well under a hundred cycles
    initial begin
        #20000;
        bad_count++;
        stop_test();
    end
endmodule // tb_insn_format_field_decoder
